// ### design/sfc_params.svh
// Constants of the SPI memory command front end
`ifndef SFC_PARAMS_SVH
`define SFC_PARAMS_SVH
`define SFC_OP_SET_LATCH 8'h06
`define SFC_OP_CLR_LATCH 8'h04
`define SFC_OP_STAT_RD 8'h05
`define SFC_OP_STAT_WR 8'h01
`define SFC_OP_READ 8'h03
`define SFC_OP_FAST_READ 8'h0b
`define SFC_OP_WRITE 8'h02
`define SFC_OP_SLEEP 8'hb9
`define SFC_OP_ID_READ 8'h9f
`define SFC_SR_PG_EN 7
`define SFC_SR_ONE 6
`define SFC_SR_BG_HI 3
`define SFC_SR_BG_LO 2
`define SFC_SR_LATCH 1
`define SFC_RST_PG_EN 1'b0
`define SFC_RST_BG_HI 1'b0
`define SFC_RST_BG_LO 1'b0
`define SFC_EV_SET 0
`define SFC_EV_CLR 1
`define SFC_EV_SWR 2
`define SFC_EV_MEM 3
`define SFC_EV_NUM 4
`define SFC_ADDR_BYTES 3
`define SFC_MCLK_PERIOD_NS 40
`define SFC_POWERUP_WAIT_NS 1000
`define SFC_POWERUP_CYCLES \
  ((`SFC_POWERUP_WAIT_NS + `SFC_MCLK_PERIOD_NS - 1) / `SFC_MCLK_PERIOD_NS)
`endif

// ### design/sfc_pkg.sv
// Types of the SPI memory command front end
`include "sfc_params.svh"
package sfc_pkg;
  typedef enum logic [3:0] {
    SFC_CMD_SET, SFC_CMD_CLR, SFC_CMD_SRD, SFC_CMD_SWR, SFC_CMD_RD,
    SFC_CMD_FRD, SFC_CMD_WR, SFC_CMD_SLEEP, SFC_CMD_ID, SFC_CMD_NONE
  } sfc_cmd_type;

  typedef enum logic [2:0] {
    SFC_ST_OPC, SFC_ST_STAT_RD, SFC_ST_STAT_WR, SFC_ST_MEM_WR,
    SFC_ST_PASS, SFC_ST_IGNORE, SFC_ST_DONE
  } sfc_state_type;

  typedef struct packed {
    logic pin_guard_enable;
    logic one;
    logic zero5;
    logic zero4;
    logic block_guard_hi;
    logic block_guard_lo;
    logic write_latch_flag;
    logic zero0;
  } sfc_status_type;

  function automatic sfc_cmd_type sfc_decode(input logic [7:0] op);
    case (op)
      `SFC_OP_SET_LATCH: sfc_decode = SFC_CMD_SET;
      `SFC_OP_CLR_LATCH: sfc_decode = SFC_CMD_CLR;
      `SFC_OP_STAT_RD: sfc_decode = SFC_CMD_SRD;
      `SFC_OP_STAT_WR: sfc_decode = SFC_CMD_SWR;
      `SFC_OP_READ: sfc_decode = SFC_CMD_RD;
      `SFC_OP_FAST_READ: sfc_decode = SFC_CMD_FRD;
      `SFC_OP_WRITE: sfc_decode = SFC_CMD_WR;
      `SFC_OP_SLEEP: sfc_decode = SFC_CMD_SLEEP;
      `SFC_OP_ID_READ: sfc_decode = SFC_CMD_ID;
      default: sfc_decode = SFC_CMD_NONE;
    endcase
  endfunction : sfc_decode
endpackage : sfc_pkg

// ### design/sfc_frontend.sv
// SPI target front end: framing, opcode decode, write latch, status register
`timescale 1ns/10ps
`default_nettype none
`include "sfc_params.svh"
module sfc_frontend
  import sfc_pkg::*;
#(
  parameter int POWERUP_CYCLES = `SFC_POWERUP_CYCLES
)(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic spi_clk,
  input wire logic cs_n,
  input wire logic sdi,
  input wire logic wp_n,
  output logic sdo,
  output logic sdo_oe,
  output sfc_status_type status,
  output logic mode3_seen,
  output logic dev_ready
);

  // ---------------- Link domain (spi_clk, frame reset by cs_n high)
  sfc_state_type state_r, state_nxt;
  logic [2:0] bit_cnt_r;
  logic [2:0] byte_idx_r;
  logic [6:0] sh_r;
  logic [7:0] out_sh_r;
  logic sdo_r;
  logic oe_r;
  logic [`SFC_EV_NUM-1:0] ev_tgl_r, ev_tgl_nxt;
  logic [7:0] swr_byte_r;
  sfc_status_type status_r;

  wire [7:0] rx_byte = {sh_r, sdi};
  wire byte_done = (bit_cnt_r == 3'h7);
  wire sfc_cmd_type cmd = sfc_decode(rx_byte);
  wire opc_done = byte_done && (state_r == SFC_ST_OPC);
  wire [2:0] byte_idx_nxt = (byte_idx_r == 3'h7) ? byte_idx_r : byte_idx_r + 3'h1;
  wire first_wr_data = byte_done && (state_r == SFC_ST_MEM_WR) &&
                       (byte_idx_r == 3'(`SFC_ADDR_BYTES + 1));
  wire swr_done = byte_done && (state_r == SFC_ST_STAT_WR);

  always_comb
  begin
    state_nxt = state_r;
    if (byte_done)
    begin
      case (state_r)
        SFC_ST_OPC:
        begin
          case (cmd)
            SFC_CMD_SET, SFC_CMD_CLR: state_nxt = SFC_ST_DONE;
            SFC_CMD_SRD: state_nxt = SFC_ST_STAT_RD;
            SFC_CMD_SWR: state_nxt = SFC_ST_STAT_WR;
            SFC_CMD_WR: state_nxt = SFC_ST_MEM_WR;
            SFC_CMD_RD, SFC_CMD_FRD, SFC_CMD_SLEEP, SFC_CMD_ID: state_nxt = SFC_ST_PASS;
            default: state_nxt = SFC_ST_IGNORE;
          endcase
        end
        SFC_ST_STAT_RD, SFC_ST_STAT_WR: state_nxt = SFC_ST_DONE;
        default: state_nxt = state_r;
      endcase
    end
  end

  // Frame state cleared whenever select is high
  always_ff @(posedge spi_clk or posedge cs_n)
  begin
    if (cs_n)
    begin
      state_r <= SFC_ST_OPC;
      bit_cnt_r <= 3'h0;
      byte_idx_r <= 3'h0;
      sh_r <= 7'h00;
      out_sh_r <= 8'h00;
    end
    else
    begin
      bit_cnt_r <= bit_cnt_r + 3'h1;
      sh_r <= rx_byte[6:0];
      state_r <= state_nxt;
      if (byte_done)
        byte_idx_r <= byte_idx_nxt;
      if (opc_done && cmd == SFC_CMD_SRD)
        out_sh_r <= status_r;
    end
  end

  // Output changes on falling edges, and is cleared when select goes high
  always_ff @(negedge spi_clk or posedge cs_n)
  begin
    if (cs_n)
    begin
      sdo_r <= 1'b0;
      oe_r <= 1'b0;
    end
    else
    begin
      oe_r <= (state_r == SFC_ST_STAT_RD);
      sdo_r <= out_sh_r[~bit_cnt_r];
    end
  end

  assign sdo = sdo_r;
  assign sdo_oe = oe_r;

  // Command events leave the link domain as toggles
  always_comb
  begin
    ev_tgl_nxt = ev_tgl_r;
    if (opc_done && cmd == SFC_CMD_SET)
      ev_tgl_nxt[`SFC_EV_SET] = ~ev_tgl_r[`SFC_EV_SET];
    if (opc_done && cmd == SFC_CMD_CLR)
      ev_tgl_nxt[`SFC_EV_CLR] = ~ev_tgl_r[`SFC_EV_CLR];
    if (swr_done)
      ev_tgl_nxt[`SFC_EV_SWR] = ~ev_tgl_r[`SFC_EV_SWR];
    if (first_wr_data)
      ev_tgl_nxt[`SFC_EV_MEM] = ~ev_tgl_r[`SFC_EV_MEM];
  end

  always_ff @(posedge spi_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ev_tgl_r <= '0;
      swr_byte_r <= 8'h00;
    end
    else
    begin
      ev_tgl_r <= cs_n ? ev_tgl_r : ev_tgl_nxt;
      if (swr_done && !cs_n)
        swr_byte_r <= rx_byte;
    end
  end

  // ---------------- System domain (mclk)
  logic [`SFC_EV_NUM-1:0] ev_s1_r, ev_s2_r, ev_s3_r;
  logic cs_s1_r, cs_s2_r, cs_s3_r;
  logic ck_s1_r, ck_s2_r;
  logic wp_s1_r, wp_s2_r;
  logic mode3_r;
  logic latch_r, latch_nxt;
  logic pg_en_r, bg_hi_r, bg_lo_r;
  logic [31:0] pu_cnt_r;
  logic ready_r;

  wire [`SFC_EV_NUM-1:0] ev = (ev_s2_r ^ ev_s3_r) & {`SFC_EV_NUM{ready_r}};
  wire cs_fall = cs_s3_r && !cs_s2_r;
  wire swr_guarded = pg_en_r && !wp_s2_r;
  wire swr_ok = ev[`SFC_EV_SWR] && latch_r && !swr_guarded;
  wire mem_ok = ev[`SFC_EV_MEM] && latch_r;

  // Set wins over a clear arriving together
  always_comb
  begin
    latch_nxt = latch_r;
    if (ev[`SFC_EV_CLR] || swr_ok || mem_ok)
      latch_nxt = 1'b0;
    if (ev[`SFC_EV_SET])
      latch_nxt = 1'b1;
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      ev_s1_r <= '0;
      ev_s2_r <= '0;
      ev_s3_r <= '0;
      cs_s1_r <= 1'b1;
      cs_s2_r <= 1'b1;
      cs_s3_r <= 1'b1;
      ck_s1_r <= 1'b0;
      ck_s2_r <= 1'b0;
      wp_s1_r <= 1'b1;
      wp_s2_r <= 1'b1;
    end
    else
    begin
      ev_s1_r <= ev_tgl_r;
      ev_s2_r <= ev_s1_r;
      ev_s3_r <= ev_s2_r;
      cs_s1_r <= cs_n;
      cs_s2_r <= cs_s1_r;
      cs_s3_r <= cs_s2_r;
      ck_s1_r <= spi_clk;
      ck_s2_r <= ck_s1_r;
      wp_s1_r <= wp_n;
      wp_s2_r <= wp_s1_r;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      mode3_r <= 1'b0;
      latch_r <= 1'b0;
      pg_en_r <= `SFC_RST_PG_EN;
      bg_hi_r <= `SFC_RST_BG_HI;
      bg_lo_r <= `SFC_RST_BG_LO;
      pu_cnt_r <= 32'h0;
      ready_r <= 1'b0;
    end
    else
    begin
      if (cs_fall)
        mode3_r <= ck_s2_r;
      latch_r <= latch_nxt;
      if (swr_ok)
      begin
        pg_en_r <= swr_byte_r[`SFC_SR_PG_EN];
        bg_hi_r <= swr_byte_r[`SFC_SR_BG_HI];
        bg_lo_r <= swr_byte_r[`SFC_SR_BG_LO];
      end
      if (!ready_r)
        pu_cnt_r <= pu_cnt_r + 32'h1;
      if (pu_cnt_r >= 32'(POWERUP_CYCLES - 1))
        ready_r <= 1'b1;
    end
  end

  always_comb
  begin
    status_r = '0;
    status_r.pin_guard_enable = pg_en_r;
    status_r.one = 1'b1;
    status_r.block_guard_hi = bg_hi_r;
    status_r.block_guard_lo = bg_lo_r;
    status_r.write_latch_flag = latch_r;
  end

  assign status = status_r;
  assign mode3_seen = mode3_r;
  assign dev_ready = ready_r;

endmodule : sfc_frontend
`default_nettype wire

// ### tb/sfc_frontend_assertions.sv
// Checker for the SPI command front end
`timescale 1ns/10ps
`default_nettype none
module sfc_frontend_assertions
  import sfc_pkg::*;
#(
  parameter int POWERUP_CYCLES = 2
)(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic spi_clk,
  input wire logic cs_n,
  input wire logic sdi,
  input wire logic wp_n,
  input wire logic sdo,
  input wire logic sdo_oe,
  input wire sfc_status_type status,
  input wire logic mode3_seen,
  input wire logic dev_ready
);
  localparam int RDY_MAX = POWERUP_CYCLES + 2;
  logic rise_seen_r;
  logic [1:0] out_at_rise_r;
  always_ff @(posedge spi_clk or posedge cs_n)
    if (cs_n) rise_seen_r <= 1'b0;
    else rise_seen_r <= 1'b1;
  always_ff @(posedge spi_clk)
    out_at_rise_r <= {sdo, sdo_oe};
  chk_sr_fixed: assert property (@(posedge mclk) disable iff (!rst_n)
    status.one && !status.zero5 && !status.zero4 && !status.zero0) else $error("fixed bits");
  chk_oe_desel: assert property (@(posedge mclk) disable iff (!rst_n)
    cs_n |-> !sdo_oe && !sdo) else $error("output driven while deselected");
  chk_out_falling: assert property (@(negedge spi_clk) disable iff (cs_n)
    rise_seen_r |-> {sdo, sdo_oe} == out_at_rise_r) else $error("output moved while clock high");
  chk_ready_rise: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(rst_n) |-> ##[1:RDY_MAX] dev_ready) else $error("ready late");
  chk_ready_hold: assert property (@(posedge mclk) disable iff (!rst_n)
    dev_ready |=> dev_ready) else $error("ready dropped");
  chk_mode_frame: assert property (@(posedge mclk) disable iff (!rst_n)
    $changed(mode3_seen) |-> !cs_n || !$past(cs_n, 2)) else $error("mode moved outside frame");
  chk_guard_hold: assert property (@(posedge mclk) disable iff (!rst_n)
    status.pin_guard_enable && !wp_n && !$past(wp_n) && !$past(wp_n, 2) && !$past(wp_n, 3)
    |=> $stable(status[7:2])) else $error("guarded fields changed");
  chk_idle_stable: assert property (@(posedge mclk) disable iff (!rst_n)
    cs_n [*6] |=> $stable(status)) else $error("status moved while idle");
endmodule : sfc_frontend_assertions
bind sfc_frontend sfc_frontend_assertions #(.POWERUP_CYCLES(POWERUP_CYCLES))
  sfc_frontend_assertions_i (.mclk(mclk), .rst_n(rst_n), .spi_clk(spi_clk), .cs_n(cs_n),
  .sdi(sdi), .wp_n(wp_n), .sdo(sdo), .sdo_oe(sdo_oe), .status(status),
  .mode3_seen(mode3_seen), .dev_ready(dev_ready));
`default_nettype wire

// ### tb/sfc_host_model.sv
// SPI host model that frames commands
`timescale 1ns/10ps
`default_nettype none
module sfc_host_model (
  output logic spi_clk,
  output logic cs_n,
  output logic sdi,
  input wire logic sdo,
  input wire logic sdo_oe
);
  logic oe_seen;
  initial
  begin
    spi_clk = 1'b0;
    cs_n = 1'b1;
    sdi = 1'b0;
    oe_seen = 1'b0;
  end
  // Returns the last eight bits seen on the output
  task automatic frame(input logic m3, input logic [39:0] tx, input int nb,
                       output logic [7:0] rx);
    rx = 8'h00;
    oe_seen = 1'b0;
    spi_clk = m3;
    #16 cs_n = 1'b0;
    // Idle level held past select so the mode sampler sees it
    #96;
    for (int i = 0; i < nb; i++)
    begin
      spi_clk = 1'b0;
      sdi = tx[39 - i];
      #16 spi_clk = 1'b1;
      rx = {rx[6:0], sdo};
      oe_seen = oe_seen | sdo_oe;
      #16;
    end
    spi_clk = m3;
    #16 cs_n = 1'b1;
    sdi = ~sdi;
  endtask : frame
endmodule : sfc_host_model
`default_nettype wire

// ### tb/sfc_frontend_tb_top.sv
// Self-checking bench for the SPI command front end
`timescale 1ns/10ps
`default_nettype none
module sfc_frontend_tb_top;
  import sfc_pkg::*;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic wp_n = 1'b1;
  wire logic spi_clk, cs_n, sdi, sdo, sdo_oe, mode3_seen, dev_ready;
  sfc_status_type status;
  int bad_count = 0;
  int compares = 0;
  int cycles = 0;
  logic latch = 1'b0, pg = 1'b0, bh = 1'b0, bl = 1'b0;
  always #20 mclk = ~mclk;
  sfc_frontend #(.POWERUP_CYCLES(2)) sfc_frontend_i (.mclk(mclk), .rst_n(rst_n),
    .spi_clk(spi_clk), .cs_n(cs_n), .sdi(sdi), .wp_n(wp_n), .sdo(sdo), .sdo_oe(sdo_oe),
    .status(status), .mode3_seen(mode3_seen), .dev_ready(dev_ready));
  sfc_host_model sfc_host_model_i (.spi_clk(spi_clk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo),
    .sdo_oe(sdo_oe));
  function automatic logic [7:0] exp_sr();
    return {pg, 1'b1, 2'b00, bh, bl, latch, 1'b0};
  endfunction : exp_sr
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : give_verdict
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic send(input logic [39:0] tx, input int nb, output logic [7:0] rx);
    logic m3;
    m3 = 1'($urandom);
    @(negedge mclk);
    #($urandom % 40);
    sfc_host_model_i.frame(m3, tx, nb, rx);
    repeat (6) @(negedge mclk);
    chk("mode", {7'h00, m3}, {7'h00, mode3_seen});
  endtask : send
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      bad_count++;
      give_verdict();
    end
  end
  initial
  begin
    logic [7:0] op, d, rx;
    int k, nb;
    logic [7:0] ops [10] = '{8'h06, 8'h01, 8'h06, 8'h02, 8'h04, 8'h03, 8'h0b, 8'hb9,
                             8'h9f, 8'hc0};
    void'($urandom(32'hb590dcac));
    repeat (3) @(negedge mclk);
    rst_n = 1'b1;
    for (k = 0; k < 50 && dev_ready !== 1'b1; k++) @(negedge mclk);
    chk("ready", 8'h01, {7'h00, dev_ready});
    chk("reset status", 8'h40, status);
    for (k = 0; k < 60; k++)
    begin
      op = (k < 10) ? ops[k] : ops[$urandom % 10];
      if (op == 8'hc0) op = {4'hc, 4'($urandom)};
      nb = ($urandom % 6 == 0) ? 5 + $urandom % 3 : 40;
      d = 8'($urandom);
      wp_n = (k < 10) ? 1'b1 : 1'($urandom);
      send({op, d, 24'($urandom)}, nb, rx);
      chk("undriven", 8'h00, {7'h00, sfc_host_model_i.oe_seen});
      if (nb == 40)
        case (op)
          8'h06: latch = 1'b1;
          8'h04: latch = 1'b0;
          8'h02: latch = 1'b0;
          8'h01: if (latch && !(pg && !wp_n)) {pg, bh, bl, latch} = {d[7], d[3], d[2], 1'b0};
          default: ;
        endcase
      send({8'h05, 32'h0}, 16, rx);
      chk("status shifted", exp_sr(), rx);
      chk("status port", exp_sr(), status);
      $display("test %0d op %h bits %0d done", k, op, nb);
    end
    give_verdict();
  end
endmodule : sfc_frontend_tb_top
`default_nettype wire
